// ==== hdl/pstrg_consts.svh ====
`ifndef PSTRG_CONSTS_SVH
`define PSTRG_CONSTS_SVH
`define PSTRG_BUF_BITS      64
`define PSTRG_CNT_W         7
`define PSTRG_IVL_W         16
`define PSTRG_DLY_W         16
`define PSTRG_CMD_RST_CH1   16'h00FF
`define PSTRG_CMD_RST_CH2   16'hFF00
`define PSTRG_SRC_RESET     3'h2
`endif

// ==== hdl/pstrg_pkg.sv ====
package pstrg_pkg;
  typedef enum logic [2:0] {
    PSTRG_SRC_SPI_DIRECT = 3'h0,
    PSTRG_SRC_SPI_BUF    = 3'h1,
    PSTRG_SRC_PIN_DIRECT = 3'h2,
    PSTRG_SRC_PIN_BUF    = 3'h3,
    PSTRG_SRC_TIMER      = 3'h4
  } pstrg_src_t;

  typedef enum logic [1:0] {
    PSTRG_PULSE_NONE  = 2'h0,
    PSTRG_PULSE_SHORT = 2'h1,
    PSTRG_PULSE_LONG  = 2'h2
  } pstrg_pulse_t;

  typedef struct packed {
    logic         valid;
    pstrg_pulse_t kind;
  } pstrg_trig_t;

  typedef struct packed {
    logic        wr;
    logic [63:0] data;
    logic [6:0]  len;
    logic        confirm;
  } pstrg_load_t;
endpackage

// ==== hdl/pstrg_interval.sv ====
`timescale 1ns/1ns
`include "pstrg_consts.svh"
module pstrg_interval
  import pstrg_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic [`PSTRG_IVL_W-1:0] period_i,
  input  wire logic [`PSTRG_DLY_W-1:0] start_dly_i,
  input  wire logic                    run_i,
  input  wire logic                    req_i,
  output logic                         tick_o,
  output logic                         pass_o
);
  logic [`PSTRG_IVL_W-1:0] cnt_r;
  logic [`PSTRG_DLY_W-1:0] dly_r;
  logic                    run_q_r;
  // Start cycle counts as delay so the first tick is held off too
  wire                     starting = run_i && !run_q_r;
  wire                     in_dly  = run_i && (starting || (dly_r != '0));
  wire                     expired = (cnt_r == '0);
  wire                     fire    = run_i && !in_dly && expired;
  wire                     restart = fire || (!run_i && req_i && expired);
  // Timer reloads one less so ticks land exactly one period apart
  wire  [`PSTRG_IVL_W-1:0] reload  = (fire && (period_i != '0)) ? period_i - 1'b1 : period_i;

  // Interval counter doubling as request filter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      dly_r   <= '0;
      run_q_r <= 1'b0;
      tick_o  <= 1'b0;
      pass_o  <= 1'b0;
    end else begin
      run_q_r <= run_i;
      if (starting) begin
        dly_r <= start_dly_i;
      end else if (in_dly) begin
        dly_r <= dly_r - 1'b1;
      end
      if (restart) begin
        cnt_r <= reload;
      end else if (!expired) begin
        cnt_r <= cnt_r - 1'b1;
      end
      tick_o <= fire;
      pass_o <= !run_i && req_i && expired;
    end
  end
endmodule

// ==== hdl/pstrg_upbuf.sv ====
`timescale 1ns/1ns
`include "pstrg_consts.svh"
module pstrg_upbuf
  import pstrg_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire pstrg_load_t load_i,
  input  wire logic        clr_i,
  input  wire logic        shift_i,
  output logic             busy_o,
  output logic             bit_o,
  output logic             wr_reject_o
);
  logic [`PSTRG_BUF_BITS-1:0] sreg_r;
  logic [`PSTRG_CNT_W-1:0]    left_r;
  logic                       busy_r;
  wire                        wr_ok  = load_i.wr && !busy_r;
  wire                        last   = (left_r == 7'h01);
  wire                        do_sh  = shift_i && busy_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sreg_r      <= '0;
      left_r      <= '0;
      busy_r      <= 1'b0;
      wr_reject_o <= 1'b0;
    end else begin
      wr_reject_o <= load_i.wr && busy_r;
      if (clr_i) begin
        sreg_r <= '0;
        left_r <= '0;
        busy_r <= 1'b0;
      end else if (wr_ok) begin
        sreg_r <= load_i.data;
        left_r <= load_i.len;
        busy_r <= load_i.confirm && (load_i.len != '0);
      end else if (do_sh) begin
        sreg_r <= {sreg_r[`PSTRG_BUF_BITS-2:0], 1'b0};
        left_r <= left_r - 1'b1;
        busy_r <= !last;
      end
    end
  end

  assign busy_o = busy_r;
  assign bit_o  = sreg_r[`PSTRG_BUF_BITS-1];
endmodule

// ==== hdl/pstrg_channel.sv ====
`timescale 1ns/1ns
`include "pstrg_consts.svh"
// What this block does
// - 64-bit upstream buffer loaded by microcontroller
// - Each sync request shifts out one bit
// - Sending starts only after confirm bit
// - Busy clears once confirmed bits sent
// - Write while busy discarded, fault set
// - Trigger command while busy ignored, fault set, in non-buffered modes
// - Command RST_CMD (0x00FF ch1, 0xFF00 ch2) resets buffer, ready
// - Tooth-gap: zero bit suppresses the pulse
// - Pulse-length: one bit gives long pulse
// - Buffer bits sent unaltered, no CRC
// - Five selectable trigger sources
// - SPI direct: command selects pulse type
// - Buffered SPI/pin: bit shapes pulse
// - Pin direct: tooth-gap from pin only
// - Timer mode: periodic pulses, buffer shaped
// - Reset source is pin without buffer
// - Buffered mode, no data: short pulse
// - Switch matrix picks internal or pins
// - Timer interval from interval register
// - Programmable delay before the first timer pulse
// - Interval filters SPI and pin triggers
// - Independent generator, own trigger pin
module pstrg_channel
  import pstrg_pkg::*;
#(
  parameter logic [15:0] RST_CMD = `PSTRG_CMD_RST_CH1
)
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire pstrg_load_t             load_i,
  input  wire logic                    cmd_wr_i,
  input  wire logic [15:0]             device_command_reg_i,
  input  wire logic                    src_wr_i,
  input  wire pstrg_src_t              src_i,
  input  wire logic                    matrix_ext_i,
  input  wire logic                    pulse_len_mode_i,
  input  wire logic [`PSTRG_IVL_W-1:0] pulse_interval_timer_reg_i,
  input  wire logic [`PSTRG_DLY_W-1:0] inter_channel_trigger_delay_i,
  input  wire logic                    spi_trig_i,
  input  wire pstrg_pulse_t            spi_kind_i,
  input  wire logic                    external_trigger_pin_i,
  input  wire logic                    fault_clr_i,
  output pstrg_trig_t                  trig_o,
  output logic                         upstream_busy_flag_o,
  output logic                         upstream_fault_flag_o,
  output pstrg_src_t                   src_o
);
  pstrg_src_t   src_r;
  pstrg_trig_t  trig_r;
  logic         busy_r;
  logic         fault_r;
  logic         pin_q_r;
  pstrg_pulse_t spi_kind_r;

  wire          buf_busy;
  wire          buf_bit;
  wire          wr_reject;
  wire          tick;
  wire          pass;

  function automatic pstrg_pulse_t shape(input logic busy, input logic b, input logic pl);
    if (!busy) begin
      shape = PSTRG_PULSE_SHORT;
    end else if (pl) begin
      shape = b ? PSTRG_PULSE_LONG : PSTRG_PULSE_SHORT;
    end else begin
      shape = b ? PSTRG_PULSE_SHORT : PSTRG_PULSE_NONE;
    end
  endfunction

  wire use_pins  = matrix_ext_i;
  wire is_timer  = (src_r == PSTRG_SRC_TIMER) && !use_pins;
  wire is_buf    = (src_r == PSTRG_SRC_SPI_BUF) || (src_r == PSTRG_SRC_PIN_BUF) || is_timer;
  wire is_spi    = (src_r == PSTRG_SRC_SPI_DIRECT) || (src_r == PSTRG_SRC_SPI_BUF);
  wire is_pin    = (src_r == PSTRG_SRC_PIN_DIRECT) || (src_r == PSTRG_SRC_PIN_BUF);
  wire pin_rise  = external_trigger_pin_i && !pin_q_r;
  wire spi_req   = spi_trig_i && is_spi && !use_pins;
  wire pin_req   = pin_rise && (is_pin || use_pins);
  wire busy_cmd  = spi_trig_i && busy_r && !is_buf;
  wire raw_req   = (spi_req || pin_req) && !busy_cmd;
  wire buf_req   = is_buf && ((is_timer && tick) || (!is_timer && pass));
  wire dir_req   = !is_buf && pass;
  wire clr_cmd   = cmd_wr_i && (device_command_reg_i == RST_CMD);
  wire shift_req = buf_req && busy_r;
  wire fault_set = wr_reject || busy_cmd;

  pstrg_trig_t trig_nxt;
  assign trig_nxt.valid = buf_req ? (shape(busy_r, buf_bit, pulse_len_mode_i) != PSTRG_PULSE_NONE)
                                  : dir_req;
  assign trig_nxt.kind  = buf_req ? shape(busy_r, buf_bit, pulse_len_mode_i)
                        : (src_r == PSTRG_SRC_SPI_DIRECT && !use_pins) ? spi_kind_r
                        : PSTRG_PULSE_SHORT;

  pstrg_upbuf u_buf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .load_i      (load_i),
    .clr_i       (clr_cmd),
    .shift_i     (shift_req),
    .busy_o      (buf_busy),
    .bit_o       (buf_bit),
    .wr_reject_o (wr_reject)
  );

  pstrg_interval u_ivl (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .period_i    (pulse_interval_timer_reg_i),
    .start_dly_i (inter_channel_trigger_delay_i),
    .run_i       (is_timer),
    .req_i       (raw_req),
    .tick_o      (tick),
    .pass_o      (pass)
  );

  // Trigger source selection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      src_r <= pstrg_src_t'(`PSTRG_SRC_RESET);
    end else if (src_wr_i) begin
      src_r <= src_i;
    end
  end

  // Pulse type of the last accepted command
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_kind_r <= PSTRG_PULSE_SHORT;
    end else if (spi_req && !busy_cmd) begin
      spi_kind_r <= spi_kind_i;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= external_trigger_pin_i;
    end
  end

  // Trigger output stage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_r <= '0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // Busy flag copy
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= buf_busy;
    end
  end

  // Sticky fault, set wins over clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_r <= 1'b0;
    end else if (fault_set) begin
      fault_r <= 1'b1;
    end else if (fault_clr_i) begin
      fault_r <= 1'b0;
    end
  end

  assign trig_o                = trig_r;
  assign upstream_busy_flag_o  = busy_r;
  assign upstream_fault_flag_o = fault_r;
  assign src_o                 = src_r;

  a_fault_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    fault_set |=> upstream_fault_flag_o) else $error("fault not set");
  a_busy_trig_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_cmd |=> ##1 !trig_o.valid) else $error("busy trigger accepted");
  a_reset_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    clr_cmd |=> ##1 !upstream_busy_flag_o) else $error("buffer reset failed");
  a_gap_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    (buf_req && busy_r && !buf_bit && !pulse_len_mode_i) |=> !trig_o.valid)
    else $error("zero bit not suppressed");
  a_long_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    (buf_req && busy_r && buf_bit && pulse_len_mode_i) |=> trig_o.kind == PSTRG_PULSE_LONG)
    else $error("long pulse missing");
  a_idle_short: assert property (@(posedge mclk_i) disable iff (rst_i)
    (buf_req && !busy_r) |=> trig_o.valid && trig_o.kind == PSTRG_PULSE_SHORT)
    else $error("no short pulse when idle");
  a_pin_short: assert property (@(posedge mclk_i) disable iff (rst_i)
    (dir_req && src_r == PSTRG_SRC_PIN_DIRECT) |=> trig_o.kind == PSTRG_PULSE_SHORT)
    else $error("pin direct not tooth gap");
  a_shift_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(upstream_busy_flag_o) |-> $past(load_i.wr, 2) && $past(load_i.confirm, 2))
    else $error("busy without confirm");
  a_trig_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
    trig_o.valid |-> $past(buf_req) || $past(dir_req))
    else $error("trigger without cause");
  a_busy_done: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(upstream_busy_flag_o) |-> $past(shift_req, 2) || $past(clr_cmd, 2))
    else $error("busy dropped early");
  a_write_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (load_i.wr && buf_busy) |=> ##1 upstream_fault_flag_o)
    else $error("busy write not flagged");
  a_src_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    src_wr_i |=> src_o == $past(src_i)) else $error("source not taken");
  a_spi_kind: assert property (@(posedge mclk_i) disable iff (rst_i)
    (dir_req && src_r == PSTRG_SRC_SPI_DIRECT && !use_pins) |=> trig_o.kind == $past(spi_kind_r))
    else $error("command pulse type lost");
  a_bit_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    (buf_req && busy_r && buf_bit) |=> trig_o.valid)
    else $error("one bit gave no pulse");
  a_matrix_pins: assert property (@(posedge mclk_i) disable iff (rst_i)
    (use_pins && spi_trig_i && !pin_rise) |=> ##1 !trig_o.valid)
    else $error("command passed in pin mode");
  a_start_delay: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(is_timer) |=> !tick) else $error("timer ignored start delay");
  a_filter_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pass && pulse_interval_timer_reg_i != '0) |=> !pass)
    else $error("request inside filter time");

  c_timer_pulse: cover property (@(posedge mclk_i) disable iff (rst_i) is_timer && tick);
  c_buf_done: cover property (@(posedge mclk_i) disable iff (rst_i)
    $fell(upstream_busy_flag_o));
  c_fault: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(upstream_fault_flag_o));
  c_busy_refuse: cover property (@(posedge mclk_i) disable iff (rst_i) busy_cmd);
  c_long: cover property (@(posedge mclk_i) disable iff (rst_i)
    trig_o.valid && trig_o.kind == PSTRG_PULSE_LONG);
endmodule

// ==== testbench/pstrg_sync_gen.sv ====
`timescale 1ns/1ns
module pstrg_sync_gen
  import pstrg_pkg::*;
#(
  parameter int SHORT_LEN = 4,
  parameter int LONG_LEN  = 8
)
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire pstrg_trig_t trig_i,
  output logic             pulse_o,
  output int               count_o
);
  int left_r;
  // One line pulse per trigger, length by kind
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      left_r  <= 0;
      count_o <= 0;
    end else if (trig_i.valid) begin
      left_r  <= (trig_i.kind == PSTRG_PULSE_LONG) ? LONG_LEN : SHORT_LEN;
      count_o <= count_o + 1;
    end else if (left_r > 0) begin
      left_r <= left_r - 1;
    end
  end
  assign pulse_o = (left_r > 0);
endmodule

// ==== testbench/pstrg_channel_test.sv ====
`timescale 1ns/1ns
module pstrg_channel_test;
  import pstrg_pkg::*;
  localparam logic [15:0] IVL = 16'h0008;
  localparam logic [15:0] DLY = 16'h0003;
  logic         mclk_i = 0, rst_i = 1, cmd_wr = 0, src_wr = 0, mext = 0, plen = 0;
  logic         strig = 0, pin = 0, fclr = 0, busy, fault, line;
  logic [15:0]  cmd = 16'h0000;
  logic [63:0]  d;
  pstrg_load_t  ld = '0;
  pstrg_src_t   src = PSTRG_SRC_PIN_DIRECT, src_q;
  pstrg_pulse_t skind = PSTRG_PULSE_SHORT, exp_q[$];
  pstrg_trig_t  trig;
  int           pulses, n, n0, n_exp = 0, error_cnt = 0, cmp_count = 0;

  pstrg_channel #(.RST_CMD(16'h00ff)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .load_i(ld),
    .cmd_wr_i(cmd_wr), .device_command_reg_i(cmd), .src_wr_i(src_wr), .src_i(src),
    .matrix_ext_i(mext), .pulse_len_mode_i(plen), .pulse_interval_timer_reg_i(IVL),
    .inter_channel_trigger_delay_i(DLY), .spi_trig_i(strig), .spi_kind_i(skind),
    .external_trigger_pin_i(pin), .fault_clr_i(fclr), .trig_o(trig),
    .upstream_busy_flag_o(busy), .upstream_fault_flag_o(fault), .src_o(src_q));
  pstrg_sync_gen u_gen (.mclk_i(mclk_i), .rst_i(rst_i), .trig_i(trig), .pulse_o(line),
    .count_o(pulses));

  always #2 mclk_i = ~mclk_i;

  task automatic close_out();
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) begin
      @(posedge mclk_i);
      #1;
    end
  endtask
  task automatic note(pstrg_pulse_t k);
    exp_q.push_back(k);
    n_exp++;
  endtask
  task automatic set_src(pstrg_src_t s);
    src = s; src_wr = 1; cyc(1); src_wr = 0; cyc(2);
  endtask
  task automatic spi(pstrg_pulse_t k);
    skind = k; strig = 1; cyc(1); strig = 0; cyc(11);
  endtask
  task automatic rise();
    pin = 1; cyc(2); pin = 0; cyc(10);
  endtask
  task automatic load(logic [63:0] v, logic [6:0] len);
    ld = '{1'b1, v, len, 1'b1}; cyc(1); ld.wr = 0; cyc(3);
  endtask
  task automatic command(logic [15:0] c);
    cmd = c; cmd_wr = 1; cyc(1); cmd_wr = 0; cyc(3);
  endtask
  task automatic wait_trig(output int k);
    k = 0;
    while (trig.valid !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    cyc(1);
  endtask

  // Each trigger output is matched against the oldest note
  always @(posedge mclk_i) begin
    if (trig.valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected pulse", 16'h0000, 16'h0001);
      else chk("pulse kind", 16'(exp_q.pop_front()), 16'(trig.kind));
    end
  end

  initial begin
    #40000;
    error_cnt++;
    close_out();
  end

  initial begin
    void'($urandom(32'ha04c));
    cyc(16);
    rst_i = 0;
    cyc(2);
    chk("source", 16'(PSTRG_SRC_PIN_DIRECT), 16'(src_q));
    chk("busy", 16'h0000, 16'(busy));
    note(PSTRG_PULSE_SHORT); rise();
    set_src(PSTRG_SRC_SPI_DIRECT);
    note(PSTRG_PULSE_LONG); spi(PSTRG_PULSE_LONG);
    note(PSTRG_PULSE_SHORT); spi(PSTRG_PULSE_SHORT);
    note(PSTRG_PULSE_SHORT); skind = PSTRG_PULSE_SHORT;
    strig = 1; cyc(1); strig = 0; cyc(2); strig = 1; cyc(1); strig = 0; cyc(10);
    mext = 1; note(PSTRG_PULSE_SHORT); rise(); spi(PSTRG_PULSE_LONG); mext = 0;
    set_src(PSTRG_SRC_SPI_BUF);
    note(PSTRG_PULSE_SHORT); spi(PSTRG_PULSE_SHORT);
    d = {$urandom(), $urandom()}; d[63:62] = 2'b10;
    load(d, 7'h06);
    chk("busy", 16'h0001, 16'(busy));
    load(~d, 7'h06);
    chk("fault", 16'h0001, 16'(fault));
    for (int i = 0; i < 6; i++) begin
      if (d[63-i]) note(PSTRG_PULSE_SHORT);
      spi(PSTRG_PULSE_SHORT);
    end
    chk("busy", 16'h0000, 16'(busy));
    fclr = 1; cyc(1); fclr = 0; cyc(2);
    chk("fault", 16'h0000, 16'(fault));
    plen = 1; set_src(PSTRG_SRC_PIN_BUF);
    d = {$urandom(), $urandom()}; d[63:62] = 2'b01;
    load(d, 7'h05);
    for (int i = 0; i < 5; i++) begin
      note(d[63-i] ? PSTRG_PULSE_LONG : PSTRG_PULSE_SHORT); rise();
    end
    chk("busy", 16'h0000, 16'(busy));
    plen = 0; set_src(PSTRG_SRC_SPI_DIRECT);
    load(d, 7'h08); spi(PSTRG_PULSE_LONG);
    chk("fault", 16'h0001, 16'(fault));
    command(16'hff00);
    chk("busy", 16'h0001, 16'(busy));
    command(16'h00ff);
    chk("busy", 16'h0000, 16'(busy));
    note(PSTRG_PULSE_SHORT); note(PSTRG_PULSE_SHORT);
    set_src(PSTRG_SRC_TIMER);
    wait_trig(n0);
    chk("timer start", 16'(DLY + 16'h0001), 16'(n0));
    wait_trig(n);
    chk("timer gap", IVL, 16'(n + 1));
    set_src(PSTRG_SRC_SPI_DIRECT);
    cyc(20);
    chk("notes left", 16'h0000, 16'(exp_q.size()));
    chk("pulse count", 16'(n_exp), 16'(pulses));
    close_out();
  end
endmodule
